// ### pkg/uart_port_map.svh
// Constants of the metering serial port: framing, bit rate limits and timing
`ifndef UART_PORT_MAP_SVH
`define UART_PORT_MAP_SVH
`define CLK_HZ          100000000
`define CYC_PER_MS      (`CLK_HZ / 1000)
`define BAUD_MIN        1200
`define BAUD_MAX        19200
`define BIT_MIN_CYC     17'((`CLK_HZ / 10 * 9) / `BAUD_MAX)
`define BIT_MAX_CYC     17'((`CLK_HZ / 10 * 11) / `BAUD_MIN)
`define T_RF_MS         20
`define T_RF_CYC        (`T_RF_MS * `CYC_PER_MS)
`define T_RTD_MIN_MS    1
`define T_RTD_MIN_CYC   (`T_RTD_MIN_MS * `CYC_PER_MS)
`define RX_BREAK_MS     40
`define RX_BREAK_CYC    (`RX_BREAK_MS * `CYC_PER_MS)
`define FRAME_LEN       4'h8
`define WR_RESP_LEN     4'h4
`define RD_RESP_LEN     4'h8
`define PAR_IDX         4'h9
`define STOP_IDX        4'hA
`define HEAD_BYTE       8'h7D
`define CTRL_READ       4'h1
`define CTRL_WRITE      4'h2
`define CTRL_BCAST      4'h4
`define CHK_ADD         8'h33
`endif

// ### pkg/uart_port_pkg.sv
// Types of the metering serial port
package uart_port_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_MEAS  = 3'b001,
        ST_BITS  = 3'b010,
        ST_DELAY = 3'b011,
        ST_TX    = 3'b100
    } port_state_t;
    typedef logic [16:0] bit_len_t;
endpackage

// ### pkg/char_tx_if.sv
// Link between the port controller and its character transmitter
`timescale 1ns/1ns
interface char_tx_if;
    logic        start;
    logic [7:0]  data;
    logic [16:0] bit_len;
    logic        abort;
    logic        busy;
    logic        line;
    modport ctl (output start, output data, output bit_len, output abort,
                 input busy, input line);
    modport ser (input start, input data, input bit_len, input abort,
                 output busy, output line);
endinterface

// ### design/char_tx.sv
// Serialiser for one 11-bit character: start, eight data bits LSB first, odd parity, stop
`timescale 1ns/1ns
`include "uart_port_map.svh"
module char_tx
    import uart_port_pkg::*;
(
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic arst_n_i,
    // Controller side
    char_tx_if.ser    txc
);
    logic [10:0] shift;
    logic [3:0]  bit_idx;
    bit_len_t    timer;
    logic        active;
    logic        line;

    // Busy covers the start cycle so the controller never sees a false idle
    assign txc.busy = active | txc.start;
    assign txc.line = line;

    // Shift out one bit per measured bit time; idle line is high
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shift   <= 11'h7FF;
            bit_idx <= 4'h0;
            timer   <= 17'h00000;
            active  <= 1'b0;
            line    <= 1'b1;
        end else if (txc.abort) begin
            active  <= 1'b0;
            line    <= 1'b1;
        end else if (txc.start && !active) begin
            // Parity bit makes the count of ones odd
            shift   <= {1'b1, ~^txc.data, txc.data, 1'b0};
            bit_idx <= 4'h0;
            timer   <= txc.bit_len - 17'h00001;
            active  <= 1'b1;
            line    <= 1'b0;
        end else if (active) begin
            if (timer == 17'h00000) begin
                if (bit_idx == `STOP_IDX) begin
                    active <= 1'b0;
                    line   <= 1'b1;
                end else begin
                    bit_idx <= bit_idx + 4'h1;
                    timer   <= txc.bit_len - 17'h00001;
                    line    <= shift[bit_idx + 4'h1]; // LSB first
                end
            end else begin
                timer <= timer - 17'h00001;
            end
        end
    end
endmodule // char_tx

// ### design/meter_uart_port.sv
// Slave serial command port: autobaud receiver, frame checker and responder
// What this block does
// - Characters are 11 bits: start low, 8 data, odd parity, stop high.
// - Data bits go least significant bit first, both directions.
// - Bit rate detected automatically between 1200 and 19200 bps.
// - Half duplex; device never receives while it transmits.
// - Device only transmits in answer to a host command.
// - Line break or software reset returns port to initial state.
// - Read and write get a response; broadcast gets none.
// - Gap over 20 ms between command characters drops the frame.
// - Response starts 1 ms after the stop-bit sample of the command's last character, mid stop bit.
// - Gap between response characters lies between 0 and 20 ms.
// - Check character is inverted sum of prior characters plus 0x33.
// - Write answer is header, control, address and check character.
// - Address upper four bits in control high nibble, lower eight in address.
`timescale 1ns/1ns
`include "uart_port_map.svh"
module meter_uart_port
    import uart_port_pkg::*;
#(
    parameter int unsigned GAP_CYC     = `T_RF_CYC,
    parameter int unsigned RESP_CYC    = `T_RTD_MIN_CYC,
    parameter int unsigned BREAK_CYC   = `RX_BREAK_CYC,
    parameter int unsigned MIN_BIT_CYC = `BIT_MIN_CYC,
    parameter int unsigned MAX_BIT_CYC = `BIT_MAX_CYC
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    // Serial link
    input  wire logic        rx_i,
    output wire logic        tx_o,
    // Chip reset request
    input  wire logic        sw_reset_i,
    // Decoded command towards the register file
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic             cmd_bcast_o,
    output logic [11:0]      cmd_addr_o,
    output logic [31:0]      cmd_wdata_o,
    input  wire logic [31:0] rd_data_i,
    // Status
    output logic             baud_lock_o
);
    char_tx_if   txc ();
    port_state_t state;
    bit_len_t    bit_len;
    bit_len_t    bit_timer;
    logic [31:0] long_timer;
    logic [31:0] break_cnt;
    logic [3:0]  bit_idx;
    logic [3:0]  byte_cnt;
    logic [7:0]  data_sr;
    logic        par_bit;
    logic        bad;
    logic [7:0]  sum;
    logic [7:0]  frame [0:7];
    logic [31:0] rd_data;
    logic        is_read;
    logic [3:0]  resp_len;
    logic [3:0]  tx_idx;
    logic        launched;
    logic [7:0]  tx_sum;
    logic [7:0]  tx_byte;
    logic        clear;
    logic        byte_done;
    logic        frame_ok;
    logic [3:0]  ctrl_op;

    char_tx u_tx (
        .mclk_i   (mclk_i),
        .arst_n_i (arst_n_i),
        .txc      (txc)
    );

    // A line held low longer than any character is a break that resets the port
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            break_cnt <= 32'h0;
        end else if (rx_i || clear) begin
            break_cnt <= 32'h0;
        end else begin
            break_cnt <= break_cnt + 32'h1;
        end
    end
    assign clear = sw_reset_i || (break_cnt == BREAK_CYC - 1);
    assign txc.abort = clear;

    // Stop-bit sample completes a character
    assign byte_done = (state == ST_BITS) && (bit_timer == 17'h00000)
                       && (bit_idx == `STOP_IDX);
    assign ctrl_op   = frame[1][3:0];
    // Head, check and parity all good before anything executes
    // Parity of the check character itself is not in bad yet, so test it here
    assign frame_ok  = !bad && (frame[0] == `HEAD_BYTE) && rx_i
                       && (^{data_sr, par_bit})
                       && (data_sr == (~sum + `CHK_ADD));

    // Port sequencer: autobaud, bit sampling, gap timeout, response delay
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state       <= ST_IDLE;
            bit_len     <= 17'h00000;
            bit_timer   <= 17'h00000;
            long_timer  <= 32'h0;
            bit_idx     <= 4'h0;
            byte_cnt    <= 4'h0;
            baud_lock_o <= 1'b0;
        end else if (clear) begin
            state       <= ST_IDLE;
            bit_len     <= 17'h00000;
            byte_cnt    <= 4'h0;
            long_timer  <= 32'h0;
            baud_lock_o <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    long_timer <= long_timer + 32'h1;
                    if (byte_cnt != 4'h0 && long_timer == GAP_CYC - 1) begin
                        byte_cnt <= 4'h0;
                    end else if (!rx_i) begin
                        bit_timer <= 17'h00000;
                        if (byte_cnt == 4'h0) begin
                            // Head byte starts with a lone low start bit
                            state <= ST_MEAS;
                        end else begin
                            state     <= ST_BITS;
                            bit_idx   <= 4'h0;
                            bit_timer <= {1'b0, bit_len[16:1]};
                        end
                    end
                end
                ST_MEAS: begin
                    if (rx_i) begin
                        if (bit_timer >= MIN_BIT_CYC && bit_timer <= MAX_BIT_CYC) begin
                            bit_len     <= bit_timer;
                            baud_lock_o <= 1'b1;
                            state       <= ST_BITS;
                            bit_idx     <= 4'h1;
                            bit_timer   <= {1'b0, bit_timer[16:1]};
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (bit_timer == MAX_BIT_CYC) begin
                        state <= ST_IDLE;
                    end else begin
                        bit_timer <= bit_timer + 17'h00001;
                    end
                end
                ST_BITS: begin
                    if (bit_timer != 17'h00000) begin
                        bit_timer <= bit_timer - 17'h00001;
                    end else if (bit_idx == 4'h0 && rx_i) begin
                        state      <= ST_IDLE; // Glitch, not a start bit
                        long_timer <= 32'h0;
                    end else if (bit_idx == `STOP_IDX) begin
                        long_timer <= 32'h0;
                        if (byte_cnt == `FRAME_LEN - 4'h1) begin
                            byte_cnt <= 4'h0;
                            state    <= (frame_ok && ctrl_op != `CTRL_BCAST) ?
                                        ST_DELAY : ST_IDLE;
                        end else begin
                            byte_cnt <= byte_cnt + 4'h1;
                            state    <= ST_IDLE;
                        end
                    end else begin
                        bit_idx   <= bit_idx + 4'h1;
                        bit_timer <= bit_len - 17'h00001;
                    end
                end
                ST_DELAY: begin
                    long_timer <= long_timer + 32'h1;
                    if (long_timer == RESP_CYC - 1) begin
                        state <= ST_TX;
                    end
                end
                ST_TX: begin
                    if (launched && !txc.busy && tx_idx == resp_len - 4'h1) begin
                        state      <= ST_IDLE; // Receiver ignores rx until here
                        long_timer <= 32'h0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Character assembly: LSB first, parity and running sum per frame
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_sr <= 8'h00;
            par_bit <= 1'b0;
            bad     <= 1'b0;
            sum     <= 8'h00;
        end else if (clear || (state == ST_IDLE && byte_cnt == 4'h0)) begin
            bad <= 1'b0;
            sum <= 8'h00;
        end else if (state == ST_BITS && bit_timer == 17'h00000) begin
            if (bit_idx >= 4'h1 && bit_idx <= 4'h8) begin
                data_sr <= {rx_i, data_sr[7:1]};
            end else if (bit_idx == `PAR_IDX) begin
                par_bit <= rx_i;
            end else if (bit_idx == `STOP_IDX) begin
                // Odd parity and high stop bit
                if (!(^{data_sr, par_bit}) || !rx_i) begin
                    bad <= 1'b1;
                end
                sum <= sum + data_sr;
            end
        end
    end

    // Frame store; the eighth character is only compared, never stored
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                frame[i] <= 8'h00;
            end
        end else if (byte_done && byte_cnt != `FRAME_LEN - 4'h1) begin
            frame[byte_cnt[2:0]] <= data_sr;
        end
    end

    // Command hand-off, one pulse per accepted frame
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_valid_o <= 1'b0;
            cmd_write_o <= 1'b0;
            cmd_bcast_o <= 1'b0;
            cmd_addr_o  <= 12'h000;
            cmd_wdata_o <= 32'h0;
        end else begin
            cmd_valid_o <= 1'b0;
            if (!clear && byte_done && byte_cnt == `FRAME_LEN - 4'h1 && frame_ok
                && (ctrl_op == `CTRL_READ || ctrl_op == `CTRL_WRITE
                    || ctrl_op == `CTRL_BCAST)) begin
                cmd_valid_o <= 1'b1;
                cmd_write_o <= (ctrl_op != `CTRL_READ);
                cmd_bcast_o <= (ctrl_op == `CTRL_BCAST);
                cmd_addr_o  <= {frame[1][7:4], frame[2]};
                cmd_wdata_o <= {frame[6], frame[5], frame[4], frame[3]};
            end
        end
    end

    // Read data is captured with the command pulse; response length by operation
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_data  <= 32'h0;
            is_read  <= 1'b0;
            resp_len <= `WR_RESP_LEN;
        end else if (cmd_valid_o) begin
            rd_data  <= rd_data_i;
            is_read  <= !cmd_write_o;
            resp_len <= cmd_write_o ? `WR_RESP_LEN : `RD_RESP_LEN;
        end
    end

    // Response byte select; last byte is the check character
    always_comb begin
        tx_byte = ~tx_sum + `CHK_ADD;
        if (tx_idx != resp_len - 4'h1) begin
            case (tx_idx)
                4'h0:    tx_byte = `HEAD_BYTE;
                4'h1:    tx_byte = {cmd_addr_o[11:8],
                                    is_read ? `CTRL_READ : `CTRL_WRITE};
                4'h2:    tx_byte = cmd_addr_o[7:0];
                4'h3:    tx_byte = rd_data[7:0];
                4'h4:    tx_byte = rd_data[15:8];
                4'h5:    tx_byte = rd_data[23:16];
                4'h6:    tx_byte = rd_data[31:24];
                default: tx_byte = 8'h00;
            endcase
        end
    end

    // Response characters follow each other with a two-clock idle gap after each stop bit
    assign txc.start   = (state == ST_TX) && !launched && !clear;
    assign txc.data    = tx_byte;
    assign txc.bit_len = bit_len;
    assign tx_o        = txc.line;

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_idx   <= 4'h0;
            launched <= 1'b0;
            tx_sum   <= 8'h00;
        end else if (state != ST_TX || clear) begin
            tx_idx   <= 4'h0;
            launched <= 1'b0;
            tx_sum   <= 8'h00;
        end else if (txc.start) begin
            launched <= 1'b1;
        end else if (!txc.busy) begin
            launched <= 1'b0;
            tx_idx   <= tx_idx + 4'h1;
            tx_sum   <= tx_sum + tx_byte;
        end
    end
endmodule // meter_uart_port

// ### verif/meter_uart_port_chk.sv
// Pin-level assertions for the serial command port
`timescale 1ns/1ns
module meter_uart_port_chk #(
    parameter int unsigned RESP_CYC = 1000
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Link and control
    input wire logic tx_o,
    input wire logic sw_reset_i,
    // Command and status
    input wire logic cmd_valid_o,
    input wire logic cmd_write_o,
    input wire logic cmd_bcast_o,
    input wire logic baud_lock_o
);
    logic [31:0] cnt;
    logic        armed;
    logic        seen;

    // Cycles since an answered command; armed until its first start bit shows
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt   <= 32'h0;
            armed <= 1'b0;
            seen  <= 1'b0;
        end else if (cmd_valid_o && !cmd_bcast_o) begin
            cnt   <= 32'h1;
            armed <= 1'b1;
            seen  <= 1'b1;
        end else begin
            cnt   <= cnt + 32'h1; // Wraps only after tens of seconds of run
            armed <= armed && tx_o;
            seen  <= seen && !sw_reset_i;
        end
    end

    property p_reset_idle;
        @(posedge mclk_i) disable iff (!arst_n_i)
        $rose(arst_n_i) |-> tx_o && !cmd_valid_o && !baud_lock_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("port not idle after reset");
    property p_pulse;
        @(posedge mclk_i) disable iff (!arst_n_i) cmd_valid_o |=> !cmd_valid_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("command pulse too long");
    property p_bcast_write;
        @(posedge mclk_i) disable iff (!arst_n_i) cmd_valid_o && cmd_bcast_o |-> cmd_write_o;
    endproperty
    a_bcast_write: assert property (p_bcast_write) else $error("broadcast not a write");
    property p_resp_delay;
        @(posedge mclk_i) disable iff (!arst_n_i)
        $fell(tx_o) && armed |-> cnt >= RESP_CYC && cnt <= RESP_CYC + 1;
    endproperty
    a_resp_delay: assert property (p_resp_delay) else $error("response delay wrong");
    property p_slave;
        @(posedge mclk_i) disable iff (!arst_n_i) $fell(tx_o) |-> seen;
    endproperty
    a_slave: assert property (p_slave) else $error("transmit without command");
    property p_start_bit;
        @(posedge mclk_i) disable iff (!arst_n_i) $fell(tx_o) |-> !tx_o [*8];
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("start bit too short");
    property p_sw_reset;
        @(posedge mclk_i) disable iff (!arst_n_i) sw_reset_i |=> tx_o && !baud_lock_o;
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("soft reset ignored");
    property p_lock;
        @(posedge mclk_i) disable iff (!arst_n_i) cmd_valid_o |-> baud_lock_o;
    endproperty
    a_lock: assert property (p_lock) else $error("command without rate lock");
endmodule // meter_uart_port_chk

bind meter_uart_port meter_uart_port_chk #(.RESP_CYC(RESP_CYC)) i_meter_uart_port_chk (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .tx_o(tx_o), .sw_reset_i(sw_reset_i),
    .cmd_valid_o(cmd_valid_o), .cmd_write_o(cmd_write_o), .cmd_bcast_o(cmd_bcast_o),
    .baud_lock_o(baud_lock_o));

// ### verif/link_host.sv
// Host side of the serial link: sends command characters, collects answers
`timescale 1ns/1ns
module link_host #(
    parameter int BIT_CYC  = 4700,
    parameter int WAIT_CYC = 3 * BIT_CYC
) (
    input  wire logic mclk_i,
    input  wire logic tx_i,
    output logic      rx_o
);
    logic par_flip = 1'b0; // Bench sets it to send characters with bad parity

    initial rx_o = 1'b1;

    // One character; stop is cut short on a frame's last so the answer is not missed
    task automatic send_char(input logic [7:0] b, input int stop_cyc);
        logic [10:0] f;
        f = {1'b1, ~^b ^ par_flip, b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(negedge mclk_i);
            rx_o = f[i];
            repeat ((i == 10 ? stop_cyc : BIT_CYC) - 1) @(negedge mclk_i);
        end
    endtask

    // Waits a bounded time for a start bit, then samples mid-bit
    task automatic get_char(output logic [7:0] b, output logic ok);
        logic [10:0] f;
        int          n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (tx_i !== 1'b0 && n < WAIT_CYC) begin
            @(negedge mclk_i);
            n++;
        end
        if (tx_i !== 1'b0) return;
        repeat (BIT_CYC / 2) @(negedge mclk_i);
        for (int i = 0; i < 11; i++) begin
            f[i] = tx_i;
            if (i < 10) repeat (BIT_CYC) @(negedge mclk_i);
        end
        b = f[8:1];
        ok = f[0] === 1'b0 && f[10] === 1'b1 && f[9] === ~^f[8:1];
    endtask
endmodule // link_host

// ### verif/meter_uart_port_tb.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ns
`include "uart_port_map.svh"
module meter_uart_port_tb;
    localparam int W    = 40;
    localparam int RESP = 200;
    localparam int GAP  = 2000;
    logic        mclk_i;
    logic        arst_n_i;
    logic        sw_reset_i;
    logic [31:0] rd_data_i;
    wire logic   rx_i;
    wire logic   tx_o;
    wire logic   cmd_valid_o;
    wire logic   cmd_write_o;
    wire logic   cmd_bcast_o;
    wire logic   [11:0] cmd_addr_o;
    wire logic   [31:0] cmd_wdata_o;
    wire logic   baud_lock_o;
    int          n_errors = 0;
    int          checks = 0;
    int          n_cmd = 0;
    logic        wr_seen;
    logic        bc_seen;

    // Short bits, gaps, break and delay keep the run near 33k cycles; break equals gap and delay is a tenth of it
    meter_uart_port #(.GAP_CYC(GAP), .RESP_CYC(RESP), .BREAK_CYC(GAP),
                      .MIN_BIT_CYC(W - 8), .MAX_BIT_CYC(W + 24)) i_meter_uart_port (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i), .rx_i(rx_i), .tx_o(tx_o),
        .sw_reset_i(sw_reset_i), .cmd_valid_o(cmd_valid_o), .cmd_write_o(cmd_write_o),
        .cmd_bcast_o(cmd_bcast_o), .cmd_addr_o(cmd_addr_o), .cmd_wdata_o(cmd_wdata_o),
        .rd_data_i(rd_data_i), .baud_lock_o(baud_lock_o));
    link_host #(.BIT_CYC(W), .WAIT_CYC(RESP + 3 * W)) i_link_host (
        .mclk_i(mclk_i), .tx_i(tx_o), .rx_o(rx_i));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // Count accepted commands and keep their kind
    always @(posedge mclk_i) begin
        if (cmd_valid_o === 1'b1) begin
            n_cmd <= n_cmd + 1;
            wr_seen <= cmd_write_o;
            bc_seen <= cmd_bcast_o;
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic send_frame(input logic [7:0] ctl, input logic [7:0] adr,
                              input logic [31:0] d, input logic [7:0] bad);
        logic [7:0] c [8];
        logic [7:0] s;
        c = '{`HEAD_BYTE, ctl, adr, d[7:0], d[15:8], d[23:16], d[31:24], 8'h00};
        s = 8'h00;
        for (int i = 0; i < 7; i++) s = s + c[i];
        c[7] = ~s + `CHK_ADD + bad;
        for (int i = 0; i < 8; i++) i_link_host.send_char(c[i], i == 7 ? W / 2 : W);
    endtask

    // Expected answer built from the command; len 4 for writes, 8 for reads
    task automatic get_resp(input logic [7:0] ctl, input logic [7:0] adr,
                            input logic [31:0] d, input int len);
        logic [7:0] c [8];
        logic [7:0] s;
        logic [7:0] b;
        logic       ok;
        c = '{`HEAD_BYTE, ctl, adr, d[7:0], d[15:8], d[23:16], d[31:24], 8'h00};
        s = 8'h00;
        for (int i = 0; i < len - 1; i++) s = s + c[i];
        c[len - 1] = ~s + `CHK_ADD;
        for (int i = 0; i < len; i++) begin
            i_link_host.get_char(b, ok);
            check("response char", {24'h0, c[i]}, {24'h0, b});
            check("response framing", 32'h1, {31'h0, ok});
        end
    endtask

    task automatic quiet(input string what);
        int lows;
        lows = 0;
        repeat (RESP + 3 * W) begin
            @(negedge mclk_i);
            if (tx_o !== 1'b1) lows++;
        end
        check(what, 32'h0, lows);
    endtask

    task automatic t_write();
        int n0;
        n0 = n_cmd;
        send_frame({4'hA, `CTRL_WRITE}, 8'h5C, 32'h1234_5678, 8'h00);
        get_resp({4'hA, `CTRL_WRITE}, 8'h5C, 32'h0, 4);
        check("write count", n0 + 1, n_cmd);
        check("write addr", 32'hA5C, {20'h0, cmd_addr_o});
        check("write data", 32'h1234_5678, cmd_wdata_o);
        check("write kind", 32'h2, {30'h0, wr_seen, bc_seen});
        repeat (W + 2 * RESP) @(negedge mclk_i); // Let the stop bit end first
        $display("test write done");
    endtask

    task automatic t_read();
        @(negedge mclk_i);
        rd_data_i = 32'h9E3C_5A17;
        send_frame({4'h3, `CTRL_READ}, 8'hE1, 32'h0, 8'h00);
        get_resp({4'h3, `CTRL_READ}, 8'hE1, 32'h9E3C_5A17, 8);
        check("read addr", 32'h3E1, {20'h0, cmd_addr_o});
        check("read kind", 32'h0, {30'h0, wr_seen, bc_seen});
        repeat (W + 2 * RESP) @(negedge mclk_i); // Let the stop bit end first
        $display("test read done");
    endtask

    task automatic t_bcast_bad();
        int n0;
        n0 = n_cmd;
        send_frame({4'h7, `CTRL_BCAST}, 8'h0F, 32'hCAFE_F00D, 8'h00);
        quiet("broadcast tx");
        check("broadcast kind", 32'h3, {30'h0, wr_seen, bc_seen});
        repeat (2 * RESP) @(negedge mclk_i);
        send_frame({4'h1, `CTRL_WRITE}, 8'h22, 32'h0000_0001, 8'h01);
        quiet("bad check tx");
        check("command count", n0 + 1, n_cmd);
        i_link_host.par_flip = 1'b1;
        send_frame({4'h1, `CTRL_WRITE}, 8'h23, 32'h0000_0002, 8'h00);
        i_link_host.par_flip = 1'b0;
        quiet("bad parity tx");
        check("parity count", n0 + 1, n_cmd);
        $display("test broadcast and bad check done");
    endtask

    task automatic t_gap_reset();
        int         n0;
        logic [7:0] b;
        logic       ok;
        n0 = n_cmd;
        i_link_host.send_char(`HEAD_BYTE, W);
        i_link_host.send_char({4'h6, `CTRL_WRITE}, W);
        repeat (GAP + W) @(negedge mclk_i);
        send_frame({4'h5, `CTRL_WRITE}, 8'hA3, 32'h0BAD_F00D, 8'h00);
        check("gap count", n0 + 1, n_cmd);
        check("gap addr", 32'h5A3, {20'h0, cmd_addr_o});
        i_link_host.get_char(b, ok);
        check("head char", {24'h0, `HEAD_BYTE}, {24'h0, b});
        sw_reset_i = 1'b1;
        @(negedge mclk_i);
        sw_reset_i = 1'b0;
        @(negedge mclk_i);
        check("lock after soft reset", 32'h0, {31'h0, baud_lock_o});
        quiet("tx after soft reset");
        $display("test gap and soft reset done");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Run needs about 33k cycles at these bit lengths; allow 100k
    initial begin
        #1_000_000;
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        conclude();
    end

    initial begin
        arst_n_i = 1'b0;
        sw_reset_i = 1'b0;
        rd_data_i = 32'h0;
        repeat (10) @(negedge mclk_i);
        arst_n_i = 1'b1;
        @(negedge mclk_i);
        check("idle tx", 32'h1, {31'h0, tx_o});
        t_write();
        t_read();
        t_bcast_bad();
        t_gap_reset();
        conclude();
    end
endmodule // meter_uart_port_tb
